// [pkg/bcc_consts.svh]
// Offsets, field positions, reset values and access codes of the break comparator
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH
// ==========================================================================
// Register indices (byte address is four times the index)
`define BCC_IDX_A_ADDR_HI     32'hFFFFFF40
`define BCC_IDX_A_ADDR_LO     32'hFFFFFF42
`define BCC_IDX_A_MASK_HI     32'hFFFFFF44
`define BCC_IDX_A_MASK_LO     32'hFFFFFF46
`define BCC_IDX_A_CYCLE       32'hFFFFFF48
`define BCC_IDX_B_ADDR_HI     32'hFFFFFF60
`define BCC_IDX_B_ADDR_LO     32'hFFFFFF62
`define BCC_IDX_B_MASK_HI     32'hFFFFFF64
`define BCC_IDX_B_MASK_LO     32'hFFFFFF66
`define BCC_IDX_B_CYCLE       32'h0FFFFF68
`define BCC_IDX_B_VAL_HI      32'hFFFFFF70
`define BCC_IDX_B_VAL_LO      32'hFFFFFF72
`define BCC_IDX_B_VMASK_HI    32'hFFFFFF74
`define BCC_IDX_B_VMASK_LO    32'hFFFFFF76
`define BCC_IDX_CONTROL       32'hFFFFFF78
`define BCC_IDX_IRQ_STATUS    32'hFFFFFF7A
`define BCC_IDX_IRQ_MASK      32'hFFFFFF7C
// ==========================================================================
// Reset value and writable bits
`define BCC_RESET_VAL         16'h0000
`define BCC_CYCLE_WMASK       16'h00FF
`define BCC_CONTROL_WMASK     16'hF4DC
`define BCC_IRQ_WMASK         16'h000F
// ==========================================================================
// Cycle select fields
`define BCC_SEL_PERIPH        7
`define BCC_SEL_CORE          6
`define BCC_SEL_DATA          5
`define BCC_SEL_FETCH         4
`define BCC_SEL_WRITE         3
`define BCC_SEL_READ          2
`define BCC_SEL_SIZE_HI       1
`define BCC_SEL_SIZE_LO       0
`define BCC_SIZE_ANY          2'h0
// ==========================================================================
// Control fields
`define BCC_CTL_A_CORE_FLAG   15
`define BCC_CTL_A_PERI_FLAG   14
`define BCC_CTL_EXT_EN        13
`define BCC_CTL_NEW_MODE      12
`define BCC_CTL_A_AFTER       10
`define BCC_CTL_B_CORE_FLAG   7
`define BCC_CTL_B_PERI_FLAG   6
`define BCC_CTL_SEQ           4
`define BCC_CTL_B_DATA_EN     3
// ==========================================================================
// Interrupt status fields
`define BCC_IRQ_A_CORE        0
`define BCC_IRQ_A_PERI        1
`define BCC_IRQ_B_CORE        2
`define BCC_IRQ_B_PERI        3
// ==========================================================================
// Write strobe patterns
`define BCC_STRB_HALF         4'h3
`define BCC_STRB_WORD         4'hF
`endif

// [pkg/bcc_pkg.sv]
// Types shared by the break comparator modules
package bcc_pkg;
   // =======================================================================
   // Bus master of the watched cycle
   typedef enum logic [1:0] {
      BCC_MST_CORE,
      BCC_MST_DMA,
      BCC_MST_EXT
   } bcc_master_t;
   // =======================================================================
   // Sequential break state
   typedef enum logic {
      BCC_SEQ_IDLE,
      BCC_SEQ_ARMED
   } bcc_seq_t;
endpackage : bcc_pkg

// [hdl/bcc_chan_match.sv]
// One break channel comparator
`timescale 1ns/100ps
`include "bcc_consts.svh"
module bcc_chan_match
   import bcc_pkg::*;
(
   input  wire logic [31:0] addr_cmp,
   input  wire logic [31:0] addr_ign,
   input  wire logic [15:0] cycle_sel,
   input  wire logic        data_en,
   input  wire logic [31:0] data_cmp,
   input  wire logic [31:0] data_ign,
   input  wire logic        ext_en,
   input  wire logic        mon_valid,
   input  wire logic [31:0] mon_addr,
   input  wire logic [31:0] mon_data,
   input  wire bcc_master_t mon_master,
   input  wire logic        mon_fetch,
   input  wire logic        mon_write,
   input  wire logic [1:0]  mon_size,
   output logic             core_hit,
   output logic             periph_hit
);
   // =======================================================================
   // Condition terms
   logic addr_ok;
   logic kind_ok;
   logic dir_ok;
   logic size_ok;
   logic data_ok;
   logic periph_src;
   logic all_ok;

   assign addr_ok = ((mon_addr ^ addr_cmp) & ~addr_ign) == 32'h0000_0000;
   assign kind_ok = mon_fetch ? cycle_sel[`BCC_SEL_FETCH] : cycle_sel[`BCC_SEL_DATA];
   assign dir_ok  = mon_write ? cycle_sel[`BCC_SEL_WRITE] : cycle_sel[`BCC_SEL_READ];
   assign size_ok = (cycle_sel[`BCC_SEL_SIZE_HI:`BCC_SEL_SIZE_LO] == `BCC_SIZE_ANY) ||
                    (cycle_sel[`BCC_SEL_SIZE_HI:`BCC_SEL_SIZE_LO] == mon_size);
   // External master data is never seen, so a data condition excludes it
   assign data_ok = !data_en ||
                    ((((mon_data ^ data_cmp) & ~data_ign) == 32'h0000_0000) &&
                     (mon_master != BCC_MST_EXT));
   assign periph_src = (mon_master == BCC_MST_DMA) || ((mon_master == BCC_MST_EXT) && ext_en);
   assign all_ok = mon_valid && addr_ok && kind_ok && dir_ok && size_ok && data_ok;
   assign core_hit   = all_ok && cycle_sel[`BCC_SEL_CORE] && (mon_master == BCC_MST_CORE);
   assign periph_hit = all_ok && cycle_sel[`BCC_SEL_PERIPH] && periph_src;
endmodule : bcc_chan_match

// [hdl/bcc_user_break_unit.sv]
// User break unit: APB registers, two break channels and interrupt
// ==========================================================================
`timescale 1ns/100ps
`include "bcc_consts.svh"
module bcc_user_break_unit
   import bcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mon_valid,
   input  wire logic [31:0] mon_addr,
   input  wire logic [31:0] mon_data,
   input  wire bcc_master_t mon_master,
   input  wire logic        mon_fetch,
   input  wire logic        mon_write,
   input  wire logic [1:0]  mon_size,
   input  wire logic        insn_retire,
   output logic             break_req,
   output logic             irq
);
   // =======================================================================
   // Register storage
   logic [15:0] a_addr_hi;
   logic [15:0] a_addr_lo;
   logic [15:0] a_mask_hi;
   logic [15:0] a_mask_lo;
   logic [15:0] a_cycle;
   logic [15:0] b_addr_hi;
   logic [15:0] b_addr_lo;
   logic [15:0] b_mask_hi;
   logic [15:0] b_mask_lo;
   logic [15:0] b_cycle;
   logic [15:0] b_val_hi;
   logic [15:0] b_val_lo;
   logic [15:0] b_vmask_hi;
   logic [15:0] b_vmask_lo;
   logic [15:0] control;
   logic [15:0] irq_status;
   logic [15:0] irq_mask;
   logic        err_q;
   logic        pend_after;
   bcc_seq_t    seq_state;
   bcc_seq_t    next_seq_state;

   // =======================================================================
   // Helper functions
   function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
      hit = (addr[9:2] == idx[7:0]);
   endfunction : hit

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                         input logic [15:0] wmask);
      merge = (old & ~wmask) | (val & wmask);
   endfunction : merge

   // =======================================================================
   // Address decode
   logic sel_a_addr_hi;
   logic sel_a_addr_lo;
   logic sel_a_mask_hi;
   logic sel_a_mask_lo;
   logic sel_a_cycle;
   logic sel_b_addr_hi;
   logic sel_b_addr_lo;
   logic sel_b_mask_hi;
   logic sel_b_mask_lo;
   logic sel_b_cycle;
   logic sel_b_val_hi;
   logic sel_b_val_lo;
   logic sel_b_vmask_hi;
   logic sel_b_vmask_lo;
   logic sel_control;
   logic sel_status;
   logic sel_mask;
   logic sel_any;
   logic sel_pair;
   logic strb_ok;
   logic acc_bad;
   logic wr_en;
   logic wr_word;

   assign sel_a_addr_hi  = hit(paddr, `BCC_IDX_A_ADDR_HI);
   assign sel_a_addr_lo  = hit(paddr, `BCC_IDX_A_ADDR_LO);
   assign sel_a_mask_hi  = hit(paddr, `BCC_IDX_A_MASK_HI);
   assign sel_a_mask_lo  = hit(paddr, `BCC_IDX_A_MASK_LO);
   assign sel_a_cycle    = hit(paddr, `BCC_IDX_A_CYCLE);
   assign sel_b_addr_hi  = hit(paddr, `BCC_IDX_B_ADDR_HI);
   assign sel_b_addr_lo  = hit(paddr, `BCC_IDX_B_ADDR_LO);
   assign sel_b_mask_hi  = hit(paddr, `BCC_IDX_B_MASK_HI);
   assign sel_b_mask_lo  = hit(paddr, `BCC_IDX_B_MASK_LO);
   assign sel_b_cycle    = hit(paddr, `BCC_IDX_B_CYCLE);
   assign sel_b_val_hi   = hit(paddr, `BCC_IDX_B_VAL_HI);
   assign sel_b_val_lo   = hit(paddr, `BCC_IDX_B_VAL_LO);
   assign sel_b_vmask_hi = hit(paddr, `BCC_IDX_B_VMASK_HI);
   assign sel_b_vmask_lo = hit(paddr, `BCC_IDX_B_VMASK_LO);
   assign sel_control    = hit(paddr, `BCC_IDX_CONTROL);
   assign sel_status     = hit(paddr, `BCC_IDX_IRQ_STATUS);
   assign sel_mask       = hit(paddr, `BCC_IDX_IRQ_MASK);
   assign sel_pair = sel_a_addr_hi | sel_a_mask_hi | sel_b_addr_hi | sel_b_mask_hi |
                     sel_b_val_hi | sel_b_vmask_hi;
   assign sel_any  = sel_pair | sel_a_addr_lo | sel_a_mask_lo | sel_a_cycle | sel_b_addr_lo |
                     sel_b_mask_lo | sel_b_cycle | sel_b_val_lo | sel_b_vmask_lo |
                     sel_control | sel_status | sel_mask;
   // Byte strobes are refused so a single byte of a 16-bit register never changes alone
   assign strb_ok  = (pstrb == `BCC_STRB_HALF) || (pstrb == `BCC_STRB_WORD);
   assign acc_bad  = !sel_any || (pwrite && !strb_ok);
   assign wr_en    = psel && penable && pwrite && !err_q;
   assign wr_word  = (pstrb == `BCC_STRB_WORD);

   // =======================================================================
   // APB handshake: one wait-free access phase, answer prepared at setup
   assign pready  = 1'b1;
   assign pslverr = psel && penable && err_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (psel && !penable) begin
         err_q <= acc_bad;
      end
   end

   // =======================================================================
   // Read data, latched in the setup phase
   logic [31:0] next_prdata;

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (sel_a_addr_hi) begin
         next_prdata = {a_addr_hi, a_addr_lo};
      end else if (sel_a_addr_lo) begin
         next_prdata = {16'h0000, a_addr_lo};
      end else if (sel_a_mask_hi) begin
         next_prdata = {a_mask_hi, a_mask_lo};
      end else if (sel_a_mask_lo) begin
         next_prdata = {16'h0000, a_mask_lo};
      end else if (sel_a_cycle) begin
         next_prdata = {16'h0000, a_cycle & `BCC_CYCLE_WMASK};
      end else if (sel_b_addr_hi) begin
         next_prdata = {b_addr_hi, b_addr_lo};
      end else if (sel_b_addr_lo) begin
         next_prdata = {16'h0000, b_addr_lo};
      end else if (sel_b_mask_hi) begin
         next_prdata = {b_mask_hi, b_mask_lo};
      end else if (sel_b_mask_lo) begin
         next_prdata = {16'h0000, b_mask_lo};
      end else if (sel_b_cycle) begin
         next_prdata = {16'h0000, b_cycle & `BCC_CYCLE_WMASK};
      end else if (sel_b_val_hi) begin
         next_prdata = {b_val_hi, b_val_lo};
      end else if (sel_b_val_lo) begin
         next_prdata = {16'h0000, b_val_lo};
      end else if (sel_b_vmask_hi) begin
         next_prdata = {b_vmask_hi, b_vmask_lo};
      end else if (sel_b_vmask_lo) begin
         next_prdata = {16'h0000, b_vmask_lo};
      end else if (sel_control) begin
         next_prdata = {16'h0000, control & `BCC_CONTROL_WMASK};
      end else if (sel_status) begin
         next_prdata = {16'h0000, irq_status & `BCC_IRQ_WMASK};
      end else if (sel_mask) begin
         next_prdata = {16'h0000, irq_mask & `BCC_IRQ_WMASK};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
   end

   // =======================================================================
   // Channel A registers; a word write to a high half also loads the low half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_addr_hi <= `BCC_RESET_VAL;
         a_addr_lo <= `BCC_RESET_VAL;
         a_mask_hi <= `BCC_RESET_VAL;
         a_mask_lo <= `BCC_RESET_VAL;
         a_cycle   <= `BCC_RESET_VAL;
      end else if (wr_en) begin
         if (sel_a_addr_hi) begin
            a_addr_hi <= wr_word ? pwdata[31:16] : pwdata[15:0];
         end
         if (sel_a_addr_lo || (sel_a_addr_hi && wr_word)) begin
            a_addr_lo <= pwdata[15:0];
         end
         if (sel_a_mask_hi) begin
            a_mask_hi <= wr_word ? pwdata[31:16] : pwdata[15:0];
         end
         if (sel_a_mask_lo || (sel_a_mask_hi && wr_word)) begin
            a_mask_lo <= pwdata[15:0];
         end
         if (sel_a_cycle) begin
            a_cycle <= merge(a_cycle, pwdata[15:0], `BCC_CYCLE_WMASK);
         end
      end
   end

   // =======================================================================
   // Channel B registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_addr_hi  <= `BCC_RESET_VAL;
         b_addr_lo  <= `BCC_RESET_VAL;
         b_mask_hi  <= `BCC_RESET_VAL;
         b_mask_lo  <= `BCC_RESET_VAL;
         b_cycle    <= `BCC_RESET_VAL;
         b_val_hi   <= `BCC_RESET_VAL;
         b_val_lo   <= `BCC_RESET_VAL;
         b_vmask_hi <= `BCC_RESET_VAL;
         b_vmask_lo <= `BCC_RESET_VAL;
      end else if (wr_en) begin
         if (sel_b_addr_hi) begin
            b_addr_hi <= wr_word ? pwdata[31:16] : pwdata[15:0];
         end
         if (sel_b_addr_lo || (sel_b_addr_hi && wr_word)) begin
            b_addr_lo <= pwdata[15:0];
         end
         if (sel_b_mask_hi) begin
            b_mask_hi <= wr_word ? pwdata[31:16] : pwdata[15:0];
         end
         if (sel_b_mask_lo || (sel_b_mask_hi && wr_word)) begin
            b_mask_lo <= pwdata[15:0];
         end
         if (sel_b_cycle) begin
            b_cycle <= merge(b_cycle, pwdata[15:0], `BCC_CYCLE_WMASK);
         end
         if (sel_b_val_hi) begin
            b_val_hi <= wr_word ? pwdata[31:16] : pwdata[15:0];
         end
         if (sel_b_val_lo || (sel_b_val_hi && wr_word)) begin
            b_val_lo <= pwdata[15:0];
         end
         if (sel_b_vmask_hi) begin
            b_vmask_hi <= wr_word ? pwdata[31:16] : pwdata[15:0];
         end
         if (sel_b_vmask_lo || (sel_b_vmask_hi && wr_word)) begin
            b_vmask_lo <= pwdata[15:0];
         end
      end
   end

   // =======================================================================
   // Channel comparators
   logic a_core_hit;
   logic a_peri_hit;
   logic b_core_hit;
   logic b_peri_hit;
   logic b_live;

   bcc_chan_match u_chan_a (
      .addr_cmp   ({a_addr_hi, a_addr_lo}),
      .addr_ign   ({a_mask_hi, a_mask_lo}),
      .cycle_sel  (a_cycle),
      .data_en    (1'b0),
      .data_cmp   (32'h0000_0000),
      .data_ign   (32'hFFFF_FFFF),
      .ext_en     (control[`BCC_CTL_EXT_EN]),
      .mon_valid  (mon_valid),
      .mon_addr   (mon_addr),
      .mon_data   (mon_data),
      .mon_master (mon_master),
      .mon_fetch  (mon_fetch),
      .mon_write  (mon_write),
      .mon_size   (mon_size),
      .core_hit   (a_core_hit),
      .periph_hit (a_peri_hit)
   );

   bcc_chan_match u_chan_b (
      .addr_cmp   ({b_addr_hi, b_addr_lo}),
      .addr_ign   ({b_mask_hi, b_mask_lo}),
      .cycle_sel  (b_cycle),
      .data_en    (control[`BCC_CTL_B_DATA_EN]),
      .data_cmp   ({b_val_hi, b_val_lo}),
      .data_ign   ({b_vmask_hi, b_vmask_lo}),
      .ext_en     (control[`BCC_CTL_EXT_EN]),
      .mon_valid  (mon_valid),
      .mon_addr   (mon_addr),
      .mon_data   (mon_data),
      .mon_master (mon_master),
      .mon_fetch  (mon_fetch),
      .mon_write  (mon_write),
      .mon_size   (mon_size),
      .core_hit   (b_core_hit),
      .periph_hit (b_peri_hit)
   );

   // Legacy mode leaves channel B dormant
   assign b_live = control[`BCC_CTL_NEW_MODE];

   // =======================================================================
   // Sequential arming: A must match before B may break
   logic seq_on;
   logic a_any;
   logic b_any;

   assign seq_on = control[`BCC_CTL_SEQ] && b_live;
   assign a_any  = a_core_hit || a_peri_hit;
   assign b_any  = b_live && (b_core_hit || b_peri_hit);

   always_comb begin
      next_seq_state = seq_state;
      case (seq_state)
         BCC_SEQ_IDLE: begin
            if (seq_on && a_any) begin
               next_seq_state = BCC_SEQ_ARMED;
            end
         end
         BCC_SEQ_ARMED: begin
            if (!seq_on || b_any) begin
               next_seq_state = BCC_SEQ_IDLE;
            end
         end
         default: begin
            next_seq_state = BCC_SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_state <= BCC_SEQ_IDLE;
      end else begin
         seq_state <= next_seq_state;
      end
   end

   // =======================================================================
   // Break events
   logic a_fire;
   logic b_fire;
   logic a_fetch_hit;
   logic a_now;

   // In sequential mode channel A only arms; it never breaks alone
   assign a_fire = a_any && !seq_on;
   assign b_fire = b_any && (!seq_on || (seq_state == BCC_SEQ_ARMED));
   assign a_fetch_hit = a_fire && mon_fetch && mon_master == BCC_MST_CORE;
   assign a_now = a_fire && !(a_fetch_hit && control[`BCC_CTL_A_AFTER]);

   // After-execution fetch break waits for the instruction to retire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_after <= 1'b0;
      end else if (a_fetch_hit && control[`BCC_CTL_A_AFTER]) begin
         pend_after <= 1'b1;
      end else if (insn_retire) begin
         pend_after <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_req <= 1'b0;
      end else begin
         break_req <= a_now || b_fire || (pend_after && insn_retire);
      end
   end

   // =======================================================================
   // Control register; match flags set by hardware win over a software write
   logic [15:0] ctl_set;

   assign ctl_set = (16'(a_core_hit && a_fire) << `BCC_CTL_A_CORE_FLAG) |
                    (16'(a_peri_hit && a_fire) << `BCC_CTL_A_PERI_FLAG) |
                    (16'(b_core_hit && b_fire) << `BCC_CTL_B_CORE_FLAG) |
                    (16'(b_peri_hit && b_fire) << `BCC_CTL_B_PERI_FLAG);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= `BCC_RESET_VAL;
      end else if (wr_en && sel_control) begin
         control <= merge(control, pwdata[15:0], `BCC_CONTROL_WMASK) | ctl_set;
      end else begin
         control <= control | ctl_set;
      end
   end

   // =======================================================================
   // Interrupt status (write one to clear) and mask
   logic [15:0] irq_set;

   assign irq_set = {12'h000, b_peri_hit && b_fire, b_core_hit && b_fire,
                     a_peri_hit && a_fire, a_core_hit && a_fire};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `BCC_RESET_VAL;
      end else if (wr_en && sel_status) begin
         irq_status <= (irq_status & ~(pwdata[15:0] & `BCC_IRQ_WMASK)) | irq_set;
      end else begin
         irq_status <= irq_status | irq_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= `BCC_RESET_VAL;
      end else if (wr_en && sel_mask) begin
         irq_mask <= merge(irq_mask, pwdata[15:0], `BCC_IRQ_WMASK);
      end
   end

   assign irq = |(irq_status & irq_mask);
endmodule : bcc_user_break_unit

// [verification/bcc_checker_asserts.sv]
// Port checks of the break comparator
`timescale 1ns/100ps
module bcc_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        mon_valid,
   input wire logic        insn_retire,
   input wire logic        break_req,
   input wire logic        irq,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic [3:0]  pstrb
);
   // ======================================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   AST_NO_WAIT: assert property (pready) else $error("wait");
   AST_BYTE: assert property (acc && pwrite && !(pstrb inside {4'h3, 4'hF}) |-> pslverr) else $error("byte");
   AST_ERR_ACC: assert property (pslverr |-> acc) else $error("stray");
   AST_UNMAP: assert property (acc && paddr[9:2] == 8'h00 |-> pslverr && prdata == 32'h0) else $error("unmap");
   AST_SEL_HI: assert property (acc && !pwrite && paddr[9:2] inside {8'h48, 8'h68} |-> prdata[31:8] == 24'h0)
      else $error("sel");
   AST_BRK: assert property (break_req |-> $past(mon_valid) || $past(insn_retire)) else $error("brk");
   AST_IRQ_UP: assert property ($rose(irq) |-> $past(mon_valid) || $past(acc && pwrite)) else $error("up");
   AST_IRQ_DN: assert property ($fell(irq) |-> $past(acc && pwrite)) else $error("down");
   cover property (break_req);
   cover property ($rose(irq));
   cover property (pslverr);
endmodule : bcc_checker
bind bcc_user_break_unit bcc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
   .mon_valid, .insn_retire, .break_req, .irq, .paddr, .prdata, .pstrb);

// [verification/bcc_bus_model.sv]
// Source of watched bus cycles
`timescale 1ns/100ps
module bcc_bus_model
   import bcc_pkg::*;
(
   input  wire logic   pclk,
   output logic        mon_valid,
   output logic        mon_fetch,
   output logic        mon_write,
   output logic        insn_retire,
   output logic [1:0]  mon_size,
   output logic [31:0] mon_addr,
   output logic [31:0] mon_data,
   output bcc_master_t mon_master
);
   // ======================================================================
   // Cycles
   initial {mon_valid, mon_fetch, mon_write, insn_retire, mon_size, mon_addr, mon_data} = '0;
   initial mon_master = BCC_MST_CORE;
   task cyc(input bcc_master_t m, input logic f, w, input logic [1:0] s, input logic [31:0] a);
      @(posedge pclk);
      mon_valid <= 1'b1;
      mon_master <= m;
      mon_fetch <= f;
      mon_write <= w;
      mon_size <= s;
      mon_addr <= a;
      mon_data <= ~a;
      @(posedge pclk);
      mon_valid <= 1'b0;
      // Idle bus shows no stale address
      mon_addr <= ~a;
      mon_data <= a;
   endtask : cyc
   task retire;
      @(posedge pclk);
      insn_retire <= 1'b1;
      @(posedge pclk);
      insn_retire <= 1'b0;
   endtask : retire
endmodule : bcc_bus_model

// [verification/bcc_user_break_unit_test.sv]
// Directed test of the break comparator
`timescale 1ns/100ps
`include "bcc_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t %h", $time, a); end end
module bcc_user_break_unit_test
   import bcc_pkg::*;
;
   // ======================================================================
   // Harness
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, mon_addr, mon_data;
   logic [3:0]  pstrb = 0;
   logic        pready, pslverr, mon_valid, mon_fetch, mon_write, insn_retire, break_req, irq;
   logic [1:0]  mon_size;
   bcc_master_t mon_master;
   int          num_errors = 0, n_compared = 0, cyc_cnt = 0;
   localparam logic [31:0] HIT = 32'h5A5A10AB;
   always #12.5 pclk = ~pclk;
   bcc_user_break_unit dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .mon_valid, .mon_addr, .mon_data, .mon_master, .mon_fetch, .mon_write, .mon_size,
      .insn_retire, .break_req, .irq);
   bcc_bus_model bm (.pclk, .mon_valid, .mon_fetch, .mon_write, .insn_retire, .mon_size, .mon_addr,
      .mon_data, .mon_master);
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   always @(posedge pclk) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         num_errors++;
         end_sim;
      end
   end
   // Read compares d; write expects only the error flag
   task xf(input logic w, input logic [31:0] idx, d, input logic [3:0] s, input logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, idx << 2, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      `CHK(pslverr, e)
      if (!w) `CHK(prdata, d)
      {psel, penable} <= 2'b00;
   endtask : xf
   task bus(input bcc_master_t m, input logic f, w, input logic [1:0] s, input logic [31:0] a, input logic e);
      bm.cyc(m, f, w, s, a);
      #1;
      `CHK(break_req, e)
   endtask : bus
   // ======================================================================
   // Tests
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      xf(0, `BCC_IDX_A_MASK_HI, 32'h0, 4'h0, 0);
      xf(0, `BCC_IDX_CONTROL, 32'h0, 4'h0, 0);
      xf(1, `BCC_IDX_A_ADDR_HI, 32'h5A5A1000, 4'hF, 0);
      xf(0, `BCC_IDX_A_ADDR_HI, 32'h5A5A1000, 4'h0, 0);
      xf(0, `BCC_IDX_A_ADDR_LO, 32'h00001000, 4'h0, 0);
      xf(1, `BCC_IDX_A_MASK_LO, 32'h000000FF, 4'h3, 0);
      xf(1, `BCC_IDX_A_CYCLE, 32'h00000064, 4'hF, 0);
      xf(1, `BCC_IDX_A_CYCLE, 32'h0, 4'h1, 1);
      xf(0, `BCC_IDX_A_CYCLE, 32'h64, 4'h0, 0);
      xf(0, 32'h0, 32'h0, 4'h0, 1);
      xf(1, `BCC_IDX_IRQ_MASK, 32'hF, 4'h3, 0);
      $display("test registers done");
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 1);
      `CHK(irq, 1'b1)
      xf(0, `BCC_IDX_CONTROL, 32'h8000, 4'h0, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT ^ 32'h100, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT ^ 32'h20, 1);
      bus(BCC_MST_CORE, 0, 1, 2'h2, HIT, 0);
      bus(BCC_MST_CORE, 1, 0, 2'h2, HIT, 0);
      bus(BCC_MST_DMA, 0, 0, 2'h2, HIT, 0);
      xf(1, `BCC_IDX_IRQ_STATUS, 32'h1, 4'h3, 0);
      #1;
      `CHK(irq, 1'b0)
      xf(0, `BCC_IDX_CONTROL, 32'h8000, 4'h0, 0);
      $display("test match done");
      xf(1, `BCC_IDX_A_CYCLE, 32'h67, 4'h3, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h3, HIT, 1);
      xf(1, `BCC_IDX_A_CYCLE, 32'h65, 4'h3, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h1, HIT, 1);
      xf(1, `BCC_IDX_A_CYCLE, 32'hA4, 4'h3, 0);
      bus(BCC_MST_DMA, 0, 0, 2'h2, HIT, 1);
      bus(BCC_MST_EXT, 0, 0, 2'h2, HIT, 0);
      xf(1, `BCC_IDX_CONTROL, 32'h2000, 4'h3, 0);
      bus(BCC_MST_EXT, 0, 0, 2'h2, HIT, 1);
      xf(0, `BCC_IDX_CONTROL, 32'h6000, 4'h0, 0);
      $display("test select done");
      xf(1, `BCC_IDX_CONTROL, 32'h0400, 4'h3, 0);
      xf(1, `BCC_IDX_A_CYCLE, 32'h54, 4'h3, 0);
      bus(BCC_MST_CORE, 1, 0, 2'h2, HIT, 0);
      bm.retire;
      #1;
      `CHK(break_req, 1'b1)
      xf(1, `BCC_IDX_A_CYCLE, 32'h0, 4'h3, 0);
      xf(1, `BCC_IDX_B_MASK_HI, 32'hFFFFFFFF, 4'hF, 0);
      xf(1, `BCC_IDX_B_CYCLE, 32'hFC, 4'h3, 0);
      xf(1, `BCC_IDX_CONTROL, 32'h0, 4'h3, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 0);
      xf(1, `BCC_IDX_CONTROL, 32'h1000, 4'h3, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 1);
      // Data compare on channel B; the model drives the inverted address as data
      xf(1, `BCC_IDX_B_VAL_HI, ~HIT, 4'hF, 0);
      xf(1, `BCC_IDX_CONTROL, 32'h1008, 4'h3, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 1);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT ^ 32'h1, 0);
      // Sequential: first A hit only arms, the next B hit breaks
      xf(1, `BCC_IDX_A_CYCLE, 32'h64, 4'h3, 0);
      xf(1, `BCC_IDX_CONTROL, 32'h1010, 4'h3, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 0);
      bus(BCC_MST_CORE, 0, 0, 2'h2, HIT, 1);
      $display("test modes done");
      end_sim;
   end
endmodule : bcc_user_break_unit_test
